// ==== hw/sr_trig_pkg.sv ====
// Purpose: Shared constants for the rectifier trigger and disable control
// Assumes: Single 10 MHz timing clock, all durations held as cycle counts
// Notes:   Least times round up, recovery alone rounds down
package sr_trig_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TMR_W         = 16;

  // Durations in ns, as plain defaults
  localparam int unsigned BLANK_NS      = 300;
  localparam int unsigned MIN_ON_NS     = 500;
  localparam int unsigned MIN_OFF_NS    = 1000;
  localparam int unsigned DIS_ENTRY_NS  = 10000;
  localparam int unsigned DIS_EXIT_NS   = 2000;
  localparam int unsigned RECOVERY_NS   = 5000;

  // Cycle counts derived from the clock period
  localparam logic [TMR_W-1:0] BLANK_CYC     = TMR_W'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] MIN_ON_CYC    = TMR_W'((MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] MIN_OFF_CYC   = TMR_W'((MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] DIS_ENTRY_CYC = TMR_W'((DIS_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] DIS_EXIT_CYC  = TMR_W'((DIS_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] RECOVERY_CYC  = TMR_W'(RECOVERY_NS / CLK_PERIOD_NS);

  // Timer slots
  localparam int unsigned NUM_TMR   = 6;
  localparam int unsigned T_BLANK   = 0;
  localparam int unsigned T_MIN_ON  = 1;
  localparam int unsigned T_MIN_OFF = 2;
  localparam int unsigned T_DIS_IN  = 3;
  localparam int unsigned T_DIS_OUT = 4;
  localparam int unsigned T_RECOVER = 5;

  typedef enum logic [2:0] {
    ST_RECOVER  = 3'h0,
    ST_WAIT_OFF = 3'h1,
    ST_ARMED    = 3'h2,
    ST_ON       = 3'h3,
    ST_DISABLE  = 3'h4
  } ctrl_state_t;

endpackage : sr_trig_pkg

// ==== hw/dur_timer.sv ====
// Purpose: Up counter that flags a completed duration
// Assumes: clear_i has priority over run_i
// Notes:   done_o stays high until cleared; the count saturates
`timescale 1ns/1ps
module dur_timer (
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_i,
  input  wire logic                          clear_i,
  input  wire logic                          run_i,
  input  wire logic [sr_trig_pkg::TMR_W-1:0] len_i,
  output logic                               done_o
);

  logic [sr_trig_pkg::TMR_W-1:0] cnt_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || clear_i) begin
      cnt_q <= '0;
    end else if (run_i && (cnt_q < len_i)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done_o = (cnt_q >= len_i);

endmodule : dur_timer

// ==== hw/cross_detect.sv ====
// Purpose: Flags rising and falling crossings of a comparator result
// Assumes: Input is already on the system clock
// Notes:   Previous value resets low, so a level high at reset reads as a rise
`timescale 1ns/1ps
module cross_detect (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);

  logic prev_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_i;
    end
  end

  assign rise_o = level_i && !prev_q;
  assign fall_o = !level_i && prev_q;

endmodule : cross_detect

// ==== hw/sr_trig_ctrl.sv ====
// Purpose: Gate drive decision from trigger/disable input and sense comparators
// Assumes: Comparator results arrive on clk_sys_i; analog paths live outside
// Notes:   Each decision lands one clock after its cause
// Notes on behaviour
// - High trigger forces drive off or blocks it
// - Trigger ignored for blank time after turn-on
// - Outside blanking, trigger beats sense input
// - Trigger high past entry time enters disable
// - Turn-on only on sense fall, trigger low
// - Trigger high at crossing keeps drive off
// - At blank end, trigger high ends drive
// - Narrow trigger pulse keeps full blank on-time
// - Trigger after blank overrides minimum on-time
// - Sense turn-off ends drive after minimum on
// - Early sense turn-off waits for minimum on
// - Trigger turn-off needs full rearmed minimum off
// - Drive low throughout disable mode
// - After recovery, full minimum off, then crossing
// - Drive low throughout recovery interval
// - Recovery completes even if trigger returns high
// - Sense fall below turn-on starts drive
// - Minimum off restarts on every rearm ringing
`timescale 1ns/1ps
module sr_trig_ctrl #(
  parameter logic [sr_trig_pkg::TMR_W-1:0] BLANK_LEN     = sr_trig_pkg::BLANK_CYC,
  parameter logic [sr_trig_pkg::TMR_W-1:0] MIN_ON_LEN    = sr_trig_pkg::MIN_ON_CYC,
  parameter logic [sr_trig_pkg::TMR_W-1:0] MIN_OFF_LEN   = sr_trig_pkg::MIN_OFF_CYC,
  parameter logic [sr_trig_pkg::TMR_W-1:0] DIS_ENTRY_LEN = sr_trig_pkg::DIS_ENTRY_CYC,
  parameter logic [sr_trig_pkg::TMR_W-1:0] DIS_EXIT_LEN  = sr_trig_pkg::DIS_EXIT_CYC,
  parameter logic [sr_trig_pkg::TMR_W-1:0] RECOVERY_LEN  = sr_trig_pkg::RECOVERY_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic trigger_disable_i,
  input  wire logic sense_below_on_i,
  input  wire logic sense_above_off_i,
  input  wire logic sense_above_rearm_i,
  output logic      gate_drive_o,
  output logic      disable_mode_o,
  output logic      recovering_o,
  output logic      armed_o
);

  // Timer bank wiring
  logic [sr_trig_pkg::NUM_TMR-1:0]                         tmr_run;
  logic [sr_trig_pkg::NUM_TMR-1:0]                         tmr_clr;
  logic [sr_trig_pkg::NUM_TMR-1:0]                         tmr_done;
  logic [sr_trig_pkg::NUM_TMR-1:0][sr_trig_pkg::TMR_W-1:0] tmr_len;

  sr_trig_pkg::ctrl_state_t state_q;
  sr_trig_pkg::ctrl_state_t state_d;

  logic drive_q;
  logic disable_q;
  logic recover_q;
  logic armed_q;
  logic early_off_q;
  logic on_fall;
  logic on_release;

  // Comparator flags used directly; they are clocked by the sense front end
  logic trig;
  assign trig = trigger_disable_i;

  // Timer lengths, all tunable from the top
  assign tmr_len[sr_trig_pkg::T_BLANK]   = BLANK_LEN;
  assign tmr_len[sr_trig_pkg::T_MIN_ON]  = MIN_ON_LEN;
  assign tmr_len[sr_trig_pkg::T_MIN_OFF] = MIN_OFF_LEN;
  assign tmr_len[sr_trig_pkg::T_DIS_IN]  = DIS_ENTRY_LEN;
  assign tmr_len[sr_trig_pkg::T_DIS_OUT] = DIS_EXIT_LEN;
  assign tmr_len[sr_trig_pkg::T_RECOVER] = RECOVERY_LEN;

  // Blank and minimum on both count from the first drive cycle
  assign tmr_run[sr_trig_pkg::T_BLANK]   = (state_q == sr_trig_pkg::ST_ON);
  assign tmr_clr[sr_trig_pkg::T_BLANK]   = (state_q != sr_trig_pkg::ST_ON);
  assign tmr_run[sr_trig_pkg::T_MIN_ON]  = (state_q == sr_trig_pkg::ST_ON);
  assign tmr_clr[sr_trig_pkg::T_MIN_ON]  = (state_q != sr_trig_pkg::ST_ON);

  // Minimum off runs only above rearm; dropping below restarts it
  assign tmr_run[sr_trig_pkg::T_MIN_OFF] = (state_q == sr_trig_pkg::ST_WAIT_OFF) && sense_above_rearm_i;
  assign tmr_clr[sr_trig_pkg::T_MIN_OFF] = (state_q != sr_trig_pkg::ST_WAIT_OFF) ||
                                           !sense_above_rearm_i;

  // Entry counts consecutive high trigger cycles, even during blanking
  assign tmr_run[sr_trig_pkg::T_DIS_IN]  = trig;
  assign tmr_clr[sr_trig_pkg::T_DIS_IN]  = !trig || (state_q == sr_trig_pkg::ST_DISABLE) ||
                                           (state_q == sr_trig_pkg::ST_RECOVER);

  // Exit counts consecutive low trigger cycles while disabled
  assign tmr_run[sr_trig_pkg::T_DIS_OUT] = (state_q == sr_trig_pkg::ST_DISABLE) && !trig;
  assign tmr_clr[sr_trig_pkg::T_DIS_OUT] = (state_q != sr_trig_pkg::ST_DISABLE) || trig;

  // Recovery ignores the trigger once started
  assign tmr_run[sr_trig_pkg::T_RECOVER] = (state_q == sr_trig_pkg::ST_RECOVER);
  assign tmr_clr[sr_trig_pkg::T_RECOVER] = (state_q != sr_trig_pkg::ST_RECOVER);

  genvar gi;
  generate
    for (gi = 0; gi < sr_trig_pkg::NUM_TMR; gi++) begin : g_tmr
      dur_timer u_tmr (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .clear_i   (tmr_clr[gi]),
        .run_i     (tmr_run[gi]),
        .len_i     (tmr_len[gi]),
        .done_o    (tmr_done[gi])
      );
    end
  endgenerate

  // Falling sense crossing below turn-on level
  cross_detect u_on_cross (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .level_i   (sense_below_on_i),
    .rise_o    (on_fall),
    .fall_o    ()
  );

  // Sense-based release once minimum on has run
  assign on_release = (sense_above_off_i || early_off_q) && tmr_done[sr_trig_pkg::T_MIN_ON];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sr_trig_pkg::ST_RECOVER: begin
        if (tmr_done[sr_trig_pkg::T_RECOVER]) begin
          state_d = sr_trig_pkg::ST_WAIT_OFF;
        end
      end
      sr_trig_pkg::ST_WAIT_OFF: begin
        if (tmr_done[sr_trig_pkg::T_DIS_IN]) begin
          state_d = sr_trig_pkg::ST_DISABLE;
        end else if (tmr_done[sr_trig_pkg::T_MIN_OFF]) begin
          state_d = sr_trig_pkg::ST_ARMED;
        end
      end
      sr_trig_pkg::ST_ARMED: begin
        if (tmr_done[sr_trig_pkg::T_DIS_IN]) begin
          state_d = sr_trig_pkg::ST_DISABLE;
        end else if (on_fall && !trig) begin
          state_d = sr_trig_pkg::ST_ON;
        end
        // Crossing with trigger high is dropped, next one needed
      end
      sr_trig_pkg::ST_ON: begin
        if (tmr_done[sr_trig_pkg::T_DIS_IN]) begin
          state_d = sr_trig_pkg::ST_DISABLE;
        end else if (tmr_done[sr_trig_pkg::T_BLANK] && trig) begin
          state_d = sr_trig_pkg::ST_WAIT_OFF;
        end else if (!trig && on_release) begin
          state_d = sr_trig_pkg::ST_WAIT_OFF;
        end
        // Inside blanking the trigger is not looked at
      end
      sr_trig_pkg::ST_DISABLE: begin
        if (tmr_done[sr_trig_pkg::T_DIS_OUT]) begin
          state_d = sr_trig_pkg::ST_RECOVER;
        end
      end
      default: begin
        state_d = sr_trig_pkg::ST_WAIT_OFF;
      end
    endcase
  end

  // Power-up lands in the off-time wait, as after recovery ends
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= sr_trig_pkg::ST_WAIT_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Early sense turn-off is remembered until minimum on ends
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      early_off_q <= 1'b0;
    end else if (state_d != sr_trig_pkg::ST_ON) begin
      early_off_q <= 1'b0;
    end else if (state_q == sr_trig_pkg::ST_ON && sense_above_off_i) begin
      early_off_q <= 1'b1;
    end
  end

  // Drive follows the next state so it changes with the state itself
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= (state_d == sr_trig_pkg::ST_ON);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      disable_q <= 1'b0;
      recover_q <= 1'b0;
      armed_q   <= 1'b0;
    end else begin
      disable_q <= (state_d == sr_trig_pkg::ST_DISABLE);
      recover_q <= (state_d == sr_trig_pkg::ST_RECOVER);
      armed_q   <= (state_d == sr_trig_pkg::ST_ARMED) || (state_d == sr_trig_pkg::ST_ON);
    end
  end

  assign gate_drive_o   = drive_q;
  assign disable_mode_o = disable_q;
  assign recovering_o   = recover_q;
  assign armed_o        = armed_q;

  // Checks on the control decisions

  disable_low_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_DISABLE) |-> !gate_drive_o && disable_mode_o)
    else $error("drive high in disable mode");

  recover_low_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_RECOVER && !tmr_done[sr_trig_pkg::T_RECOVER])
    |=> (state_q == sr_trig_pkg::ST_RECOVER) && !gate_drive_o)
    else $error("recovery left early or drive high");

  recover_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(recovering_o) |-> recovering_o [*2] ##0 !disable_mode_o)
    else $error("recovery interrupted");

  blank_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_ON && !tmr_done[sr_trig_pkg::T_BLANK] && !tmr_done[sr_trig_pkg::T_DIS_IN]
     && !tmr_done[sr_trig_pkg::T_MIN_ON]) |=> gate_drive_o)
    else $error("drive dropped inside blanking");

  trig_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_ON && tmr_done[sr_trig_pkg::T_BLANK] && trigger_disable_i)
    |=> !gate_drive_o ##1 !gate_drive_o)
    else $error("trigger did not end drive");

  crossing_on_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(gate_drive_o) |-> $past(on_fall) && !$past(trigger_disable_i)
                            && $past(state_q == sr_trig_pkg::ST_ARMED))
    else $error("drive rose without clean crossing");

  trig_block_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_ARMED && on_fall && trigger_disable_i) |=> !gate_drive_o)
    else $error("drive rose with trigger high");

  sense_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_ON && !trigger_disable_i && sense_above_off_i
     && tmr_done[sr_trig_pkg::T_MIN_ON]) |=> !gate_drive_o)
    else $error("sense turn-off ignored");

  min_on_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_ON && !trigger_disable_i && !tmr_done[sr_trig_pkg::T_MIN_ON])
    |=> gate_drive_o)
    else $error("drive dropped before minimum on");

  off_wait_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_WAIT_OFF && !tmr_done[sr_trig_pkg::T_MIN_OFF]) |=> !gate_drive_o)
    else $error("drive before full minimum off");

  rearm_restart_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_WAIT_OFF && !sense_above_rearm_i && MIN_OFF_LEN != '0)
    |=> !tmr_done[sr_trig_pkg::T_MIN_OFF])
    else $error("minimum off not restarted by ringing");

  disable_entry_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tmr_done[sr_trig_pkg::T_DIS_IN] && state_q != sr_trig_pkg::ST_DISABLE
     && state_q != sr_trig_pkg::ST_RECOVER) |=> disable_mode_o && !gate_drive_o)
    else $error("disable mode not entered");

  rst_outputs_a: assert property (@(posedge clk_sys_i)
    $fell(rst_i)
    |-> !gate_drive_o && !armed_o && !disable_mode_o && !recovering_o)
    else $error("outputs not idle after reset");

  rst_state_a: assert property (@(posedge clk_sys_i)
    rst_i
    |=> (state_q == sr_trig_pkg::ST_WAIT_OFF))
    else $error("reset did not land in off wait");

  blank_end_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_ON && tmr_done[sr_trig_pkg::T_BLANK] && !trigger_disable_i
     && !on_release && !tmr_done[sr_trig_pkg::T_DIS_IN])
    |=> gate_drive_o)
    else $error("drive dropped with trigger low");

  disable_stay_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_DISABLE && !tmr_done[sr_trig_pkg::T_DIS_OUT])
    |=> (state_q == sr_trig_pkg::ST_DISABLE) && !gate_drive_o)
    else $error("disable mode left early");

  exit_start_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_DISABLE && tmr_done[sr_trig_pkg::T_DIS_OUT])
    |=> recovering_o && !disable_mode_o)
    else $error("recovery not started");

  recover_end_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_RECOVER && tmr_done[sr_trig_pkg::T_RECOVER])
    |=> (state_q == sr_trig_pkg::ST_WAIT_OFF) && !recovering_o)
    else $error("recovery did not end");

  arm_after_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_WAIT_OFF && tmr_done[sr_trig_pkg::T_MIN_OFF]
     && !tmr_done[sr_trig_pkg::T_DIS_IN])
    |=> armed_o && !gate_drive_o)
    else $error("not armed after minimum off");

  armed_wait_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_ARMED && !on_fall && !tmr_done[sr_trig_pkg::T_DIS_IN])
    |=> armed_o && !gate_drive_o)
    else $error("drive without crossing");

  early_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_ON && early_off_q && !trigger_disable_i
     && tmr_done[sr_trig_pkg::T_MIN_ON] && !tmr_done[sr_trig_pkg::T_DIS_IN])
    |=> !gate_drive_o)
    else $error("early turn-off not released");

  mode_excl_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    recovering_o
    |-> !disable_mode_o && !gate_drive_o && !armed_o)
    else $error("recovery flags inconsistent");

  ring_block_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_WAIT_OFF && !sense_above_rearm_i && !tmr_done[sr_trig_pkg::T_MIN_OFF])
    |=> !armed_o)
    else $error("armed during ringing");

  trig_refuse_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == sr_trig_pkg::ST_ARMED && trigger_disable_i)
    |=> !gate_drive_o)
    else $error("drive rose with trigger high");

  off_disarm_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $fell(gate_drive_o)
    |-> !armed_o)
    else $error("still armed after turn-off");

endmodule : sr_trig_ctrl

// ==== verification/sense_partner.sv ====
// Purpose: Sense path model, maps a drain phase to comparator results
// Assumes: Phase changes only at rising clock edges
// Notes:   Levels stay mutually consistent; ringing shows as phase 2
`timescale 1ns/1ps
module sense_partner (
  input  wire logic [1:0] phase_i,
  output logic            below_on_o,
  output logic            above_off_o,
  output logic            above_rearm_o
);
  // Phase 0 positive drain, 1 conducting, 2 near zero, 3 as 0
  assign below_on_o    = (phase_i == 2'h1);
  assign above_off_o   = (phase_i != 2'h1);
  assign above_rearm_o = (phase_i == 2'h0) || (phase_i == 2'h3);
endmodule : sense_partner

// ==== verification/sr_trig_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the trigger and disable control
// Assumes: Small timer lengths; exact edges as in the hand-over walk
// Notes:   Min-on release held-checked three cycles early, off-checked at the exact drop
`timescale 1ns/1ps
module sr_trig_ctrl_tb_top;
  localparam int BL = 32'h2, MON = 32'h5, MOFF = 32'h4;
  localparam int DIN = 32'h8, DOUT = 32'h4, REC = 32'h5;
  localparam logic [1:0] POS = 2'h0, CND = 2'h1, NZ = 2'h2;
  logic       clk_sys_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       trig      = 1'b0;
  logic [1:0] ph        = 2'h0;
  logic       below_on, above_off, above_rearm;
  logic       drv, dis, recov, armed;
  int         fail_count = 0;
  int         tests_run  = 0;
  int         cycles     = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  sense_partner sense_partner_inst (
    .phase_i       (ph),
    .below_on_o    (below_on),
    .above_off_o   (above_off),
    .above_rearm_o (above_rearm)
  );

  // Shortened counts keep the run brief
  sr_trig_ctrl #(
    .BLANK_LEN     (sr_trig_pkg::TMR_W'(BL)),
    .MIN_ON_LEN    (sr_trig_pkg::TMR_W'(MON)),
    .MIN_OFF_LEN   (sr_trig_pkg::TMR_W'(MOFF)),
    .DIS_ENTRY_LEN (sr_trig_pkg::TMR_W'(DIN)),
    .DIS_EXIT_LEN  (sr_trig_pkg::TMR_W'(DOUT)),
    .RECOVERY_LEN  (sr_trig_pkg::TMR_W'(REC))
  ) sr_trig_ctrl_inst (
    .clk_sys_i           (clk_sys_i),
    .rst_i               (rst_i),
    .trigger_disable_i   (trig),
    .sense_below_on_i    (below_on),
    .sense_above_off_i   (above_off),
    .sense_above_rearm_i (above_rearm),
    .gate_drive_o        (drv),
    .disable_mode_o      (dis),
    .recovering_o        (recov),
    .armed_o             (armed)
  );

  task automatic test_done();
    $display("tests %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", name, exp, seen);
    end
  endtask : check

  task automatic drive(input logic [1:0] p, input logic t);
    @(posedge clk_sys_i);
    ph   <= p;
    trig <= t;
  endtask : drive

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wait_cyc

  task automatic arm();
    drive(POS, 1'b0);
    wait_cyc(MOFF + 2);
    check("armed", armed, 1'b1);
  endtask : arm

  // Ringing below rearm restarts the off-time after reset
  task automatic reset_arm();
    wait_cyc(2);
    drive(NZ, 1'b0);
    drive(POS, 1'b0);
    wait_cyc(MOFF);
    check("armed early", armed, 1'b0);
    check("drive", drv, 1'b0);
    wait_cyc(1);
    check("armed", armed, 1'b1);
  endtask : reset_arm

  task automatic cs_off();
    drive(CND, 1'b0);
    wait_cyc(1);
    check("drive on", drv, 1'b1);
    drive(NZ, 1'b0);
    wait_cyc(MON - 3);
    check("drive held", drv, 1'b1);
    wait_cyc(3);
    check("drive off", drv, 1'b0);
    arm();
    drive(CND, 1'b0);
    wait_cyc(MON + 3);
    check("drive long", drv, 1'b1);
    drive(NZ, 1'b0);
    wait_cyc(1);
    check("drive cs off", drv, 1'b0);
  endtask : cs_off

  // Trigger raised in the first on cycle, sense still conducting
  task automatic blank_cut();
    arm();
    drive(CND, 1'b0);
    drive(CND, 1'b1);
    wait_cyc(BL);
    check("drive blank", drv, 1'b1);
    wait_cyc(1);
    check("drive trig", drv, 1'b0);
    drive(CND, 1'b0);
    wait_cyc(MOFF + 3);
    check("no rearm", armed, 1'b0);
    drive(POS, 1'b0);
    wait_cyc(MOFF);
    check("armed early", armed, 1'b0);
    wait_cyc(1);
    check("armed", armed, 1'b1);
  endtask : blank_cut

  task automatic narrow();
    drive(CND, 1'b0);
    drive(CND, 1'b1);
    drive(CND, 1'b0);
    wait_cyc(BL + 1);
    check("drive narrow", drv, 1'b1);
    drive(NZ, 1'b0);
    wait_cyc(MON);
    check("drive end", drv, 1'b0);
  endtask : narrow

  // A crossing met with the trigger high is lost
  task automatic blocked();
    arm();
    drive(CND, 1'b1);
    wait_cyc(3);
    check("drive blocked", drv, 1'b0);
    drive(CND, 1'b0);
    wait_cyc(3);
    check("drive no edge", drv, 1'b0);
    drive(POS, 1'b0);
    drive(CND, 1'b0);
    wait_cyc(1);
    check("drive again", drv, 1'b1);
    drive(NZ, 1'b0);
    wait_cyc(MON + 1);
  endtask : blocked

  task automatic disable_cycle();
    drive(POS, 1'b1);
    wait_cyc(DIN - 2);
    check("dis early", dis, 1'b0);
    wait_cyc(3);
    check("dis", dis, 1'b1);
    drive(CND, 1'b0); // Short low phase, too brief to leave
    wait_cyc(DOUT - 2);
    check("drive dis", drv, 1'b0);
    drive(CND, 1'b1);
    wait_cyc(2);
    check("still dis", dis, 1'b1);
    check("no recov", recov, 1'b0);
    drive(POS, 1'b0);
    wait_cyc(DOUT - 1);
    drive(CND, 1'b1);
    wait_cyc(1);
    check("recov", recov, 1'b1);
    wait_cyc(REC - 2);
    check("recov held", recov, 1'b1);
    check("drive rec", drv, 1'b0);
    drive(POS, 1'b0);
    wait_cyc(3);
    check("recov end", recov, 1'b0);
    check("dis end", dis, 1'b0);
    wait_cyc(MOFF + 2);
    check("armed", armed, 1'b1);
    drive(CND, 1'b0);
    wait_cyc(1);
    check("drive back", drv, 1'b1);
  endtask : disable_cycle

  // Ceiling far above the roughly 150 cycles the run needs
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    wait_cyc(15);
    check("drive rst", drv, 1'b0);
    check("armed rst", armed, 1'b0);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    reset_arm();
    cs_off();
    blank_cut();
    narrow();
    blocked();
    disable_cycle();
    test_done();
  end
endmodule : sr_trig_ctrl_tb_top
